// File: src/dual_timer_13bit_mode.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module dual_timer_13bit_mode (
    input  wire logic                         sys_clk_i,
    input  wire logic                         srst_i,
    input  wire dual_timer_pkg::reg_req_type  req_i,
    input  wire dual_timer_pkg::timer_pins_type pins_i,
    input  wire dual_timer_pkg::vector_ack_type ack_i,
    output logic      [`REG_DATA_W-1:0]       rdata_o,
    output logic                              irq_o,
    output logic      [1:0]                   overflow_flag_o,
    output logic      [1:0]                   ext_irq_flag_o
);
    import dual_timer_pkg::*;

    // field positions per timer index
    localparam int TR_POS   [2] = '{`TR0_BIT, `TR1_BIT};
    localparam int TF_POS   [2] = '{`TF0_BIT, `TF1_BIT};
    localparam int IT_POS   [2] = '{`IT0_BIT, `IT1_BIT};
    localparam int IE_POS   [2] = '{`IE0_BIT, `IE1_BIT};
    localparam int GATE_POS [2] = '{`GATE_ENABLE_ZERO_BIT, `GATE1_BIT};
    localparam int CT_POS   [2] = '{`CT0_BIT, `CT1_BIT};
    localparam int SYS_POS  [2] = '{`SYS0_BIT, `SYS1_BIT};
    localparam int POL_POS  [2] = '{`POL0_BIT, `POL1_BIT};
    localparam int TFQ_POS  [2] = '{`IRQ_TF0, `IRQ_TF1};
    localparam int IEQ_POS  [2] = '{`IRQ_IE0, `IRQ_IE1};

    core_state_type            state;        // registered control state
    core_state_type            next_state;   // control state for the next cycle
    logic [3:0]                div_tick;     // prescaled tick pulses
    logic [1:0]                tick;         // selected tick per timer
    logic [1:0]                allow;        // counting allowed per timer
    logic [1:0]                ext_active;   // gate input active per timer
    logic [1:0]                pin_fall;     // count pin falling edge
    logic [1:0]                wr_low;       // low byte load strobes
    logic [1:0]                wr_high;      // high byte load strobes
    logic [1:0]                wrap;         // wrap pulses from the counters
    logic [1:0]                ie_set;       // external flag set events
    logic [`COUNT_W-1:0]       count [2];    // current counts
    logic [`SCALE_W-1:0]       scale;        // prescaler choice

    // shared prescaler for both timers
    prescale_divider u_divider (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .tick_o    (div_tick)
    );

    // one count unit per timer, both built alike
    for (genvar g = 0; g < 2; g++) begin : g_unit
        count_unit u_count (
            .sys_clk_i (sys_clk_i),
            .srst_i    (srst_i),
            .tick_i    (tick[g]),
            .allow_i   (allow[g]),
            .wr_low_i  (wr_low[g]),
            .wr_high_i (wr_high[g]),
            .wdata_i   (req_i.wdata),
            .count_o   (count[g]),
            .wrap_o    (wrap[g])
        );
    end

    // gate, clock source and edge logic for each timer
    always_comb begin
        scale = state.clock_scale[`SCALE_LSB +: `SCALE_W];
        for (int i = 0; i < 2; i++) begin
            // polarity set means a high level is active
            ext_active[i] = state.ext_config[POL_POS[i]] ?
                            pins_i.ext_irq_input[i] : ~pins_i.ext_irq_input[i];
            // falling edge of the count pin
            pin_fall[i]   = state.pin_prev[i] & ~pins_i.count_pin[i];
            // run bit and gate decide counting; never touches the count
            allow[i]      = state.control[TR_POS[i]] &
                            (~state.mode[GATE_POS[i]] | ext_active[i]);
            // counter mode takes pin edges, timer mode a clock
            if (state.mode[CT_POS[i]]) begin
                tick[i] = pin_fall[i];
            end else if (state.clock_scale[SYS_POS[i]]) begin
                tick[i] = 1'b1;
            end else begin
                tick[i] = div_tick[scale];
            end
            // edge mode sets on becoming active, level mode while active
            if (state.control[IT_POS[i]]) begin
                ie_set[i] = ext_active[i] & ~state.active_prev[i];
            end else begin
                ie_set[i] = ext_active[i];
            end
        end
    end

    // count byte load decode
    always_comb begin
        wr_low[0]  = req_i.wr && (req_i.addr == `OFS_ZERO_LOW);
        wr_low[1]  = req_i.wr && (req_i.addr == `OFS_ONE_LOW);
        wr_high[0] = req_i.wr && (req_i.addr == `OFS_ZERO_HIGH);
        wr_high[1] = req_i.wr && (req_i.addr == `OFS_ONE_HIGH);
    end

    // register writes, flag updates, read data and interrupt
    always_comb begin
        next_state             = state;
        next_state.pin_prev    = pins_i.count_pin;
        next_state.active_prev = ext_active;
        next_state.rdata       = `RST_BYTE;

        // software writes
        if (req_i.wr) begin
            unique case (req_i.addr)
                `OFS_PAIR_CONTROL: begin
                    next_state.control = req_i.wdata;
                end
                `OFS_MODE: begin
                    next_state.mode = req_i.wdata;
                end
                `OFS_CLOCK_SCALE: begin
                    next_state.clock_scale = req_i.wdata;
                end
                `OFS_EXT_CONFIG: begin
                    next_state.ext_config = req_i.wdata;
                end
                `OFS_IRQ_CLEAR: begin
                    // write one to clear
                    next_state.irq_status = state.irq_status & ~req_i.wdata[`IRQ_W-1:0];
                end
                `OFS_IRQ_ENABLE: begin
                    next_state.irq_enable = req_i.wdata[`IRQ_W-1:0];
                end
                default: begin
                    // counts are loaded in the units; others ignored
                end
            endcase
        end

        for (int i = 0; i < 2; i++) begin
            // vectoring clears the overflow flag
            if (ack_i.timer_vector[i]) begin
                next_state.control[TF_POS[i]] = 1'b0;
            end
            // vectoring clears the external flag only in edge mode
            if (ack_i.ext_vector[i] && state.control[IT_POS[i]]) begin
                next_state.control[IE_POS[i]] = 1'b0;
            end
            // hardware sets come last so they win over any clear
            if (wrap[i]) begin
                next_state.control[TF_POS[i]]  = 1'b1;
                next_state.irq_status[TFQ_POS[i]] = 1'b1;
            end
            if (ie_set[i]) begin
                next_state.control[IE_POS[i]]  = 1'b1;
                next_state.irq_status[IEQ_POS[i]] = 1'b1;
            end
        end

        // read data stand in the cycle after the strobe only
        if (req_i.rd) begin
            unique case (req_i.addr)
                `OFS_PAIR_CONTROL: next_state.rdata = state.control;
                `OFS_MODE:         next_state.rdata = state.mode;
                `OFS_CLOCK_SCALE:  next_state.rdata = state.clock_scale;
                `OFS_EXT_CONFIG:   next_state.rdata = state.ext_config;
                // upper three bits of a low byte read as zero
                `OFS_ZERO_LOW:     next_state.rdata = {3'h0, count[0][`LOW_W-1:0]};
                `OFS_ONE_LOW:      next_state.rdata = {3'h0, count[1][`LOW_W-1:0]};
                `OFS_ZERO_HIGH:    next_state.rdata = count[0][`COUNT_W-1:`LOW_W];
                `OFS_ONE_HIGH:     next_state.rdata = count[1][`COUNT_W-1:`LOW_W];
                `OFS_IRQ_STATUS:   next_state.rdata = {4'h0, state.irq_status};
                `OFS_IRQ_ENABLE:   next_state.rdata = {4'h0, state.irq_enable};
                default:           next_state.rdata = `RST_BYTE;
            endcase
        end

        // level interrupt while any enabled status bit is set
        next_state.irq = |(next_state.irq_status & next_state.irq_enable);
    end

    // control state register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state.control     <= `RST_BYTE;
            state.mode        <= `RST_BYTE;
            state.clock_scale <= `RST_BYTE;
            state.ext_config  <= `RST_BYTE;
            state.irq_status  <= `RST_IRQ;
            state.irq_enable  <= `RST_IRQ;
            state.rdata       <= `RST_BYTE;
            state.irq         <= 1'b0;
            state.pin_prev    <= 2'h0;
            state.active_prev <= 2'h0;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        rdata_o            = state.rdata;
        irq_o              = state.irq;
        overflow_flag_o[0] = state.control[`TF0_BIT];
        overflow_flag_o[1] = state.control[`TF1_BIT];
        ext_irq_flag_o[0]  = state.control[`IE0_BIT];
        ext_irq_flag_o[1]  = state.control[`IE1_BIT];
    end

endmodule : dual_timer_13bit_mode

// File: src/dual_timer_cfg.svh
// Behaviour
// - count is high byte then low five bits
// - low byte top three bits read meaningless; this design reads them as zero
// - wrap from all ones sets overflow flag
// - enabled overflow raises interrupt request
// - counter mode counts count pin falling edges
// - timer mode counts system or prescaled clock
// - count needs run and open gate
// - polarity bit decides active gate level
// - run bit never clears or reloads count
// - timer one mirrors timer zero
// - shared control register layout, resets zero
// - overflow flag cleared by software or vectoring
// - type bit selects level or edge trigger
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH

// register bus geometry
`define REG_ADDR_W        8
`define REG_DATA_W        8

// register offsets
`define OFS_PAIR_CONTROL  8'h88
`define OFS_MODE          8'h89
`define OFS_ZERO_LOW      8'h8A
`define OFS_ONE_LOW       8'h8B
`define OFS_ZERO_HIGH     8'h8C
`define OFS_ONE_HIGH      8'h8D
`define OFS_CLOCK_SCALE   8'h8E
`define OFS_EXT_CONFIG    8'h8F
`define OFS_IRQ_STATUS    8'h90
`define OFS_IRQ_CLEAR     8'h91
`define OFS_IRQ_ENABLE    8'h92

// reset values
`define RST_BYTE          8'h00
`define RST_IRQ           4'h0
`define RST_COUNT         13'h0000

// shared control register fields
`define TF1_BIT           7
`define TR1_BIT           6
`define TF0_BIT           5
`define TR0_BIT           4
`define IE1_BIT           3
`define IT1_BIT           2
`define IE0_BIT           1
`define IT0_BIT           0

// mode register fields
`define GATE1_BIT         7
`define CT1_BIT           6
`define GATE_ENABLE_ZERO_BIT         3
`define CT0_BIT           2

// clock scale register fields
`define SYS1_BIT          4
`define SYS0_BIT          3
`define SCALE_LSB         0
`define SCALE_W           2

// external interrupt configuration fields
`define POL1_BIT          7
`define POL0_BIT          3

// interrupt status, clear and enable layout
`define IRQ_W             4
`define IRQ_TF0           0
`define IRQ_TF1           1
`define IRQ_IE0           2
`define IRQ_IE1           3

// count geometry
`define COUNT_W           13
`define LOW_W             5
`define COUNT_ONES        13'h1FFF
`define COUNT_ONE         13'h0001

// prescaler ratios, indexed by the scale code
`define DIV_SCALE0        12
`define DIV_SCALE1        4
`define DIV_SCALE2        48
`define DIV_SCALE3        8
`define DIV_SPAN          48
`define DIV_PHASE_W       6

`endif

// File: src/dual_timer_pkg.sv
`include "dual_timer_cfg.svh"

package dual_timer_pkg;

    // one register access from software
    typedef struct packed {
        logic [`REG_ADDR_W-1:0] addr;
        logic [`REG_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } reg_req_type;

    // pins of the two timers
    typedef struct packed {
        logic [1:0] count_pin;
        logic [1:0] ext_irq_input;
    } timer_pins_type;

    // vectoring acknowledges from the cpu interrupt logic
    typedef struct packed {
        logic [1:0] timer_vector;
        logic [1:0] ext_vector;
    } vector_ack_type;

    // state of one 13-bit count unit
    typedef struct packed {
        logic [`COUNT_W-1:0] count;
    } count_state_type;

    // state of the prescaler
    typedef struct packed {
        logic [`DIV_PHASE_W-1:0] phase;
    } divider_state_type;

    // state of the register and control logic
    typedef struct packed {
        logic [`REG_DATA_W-1:0] control;
        logic [`REG_DATA_W-1:0] mode;
        logic [`REG_DATA_W-1:0] clock_scale;
        logic [`REG_DATA_W-1:0] ext_config;
        logic [`IRQ_W-1:0]      irq_status;
        logic [`IRQ_W-1:0]      irq_enable;
        logic [`REG_DATA_W-1:0] rdata;
        logic                   irq;
        logic [1:0]             pin_prev;
        logic [1:0]             active_prev;
    } core_state_type;

endpackage : dual_timer_pkg

// File: src/prescale_divider.sv
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module prescale_divider (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    output logic      [3:0] tick_o
);
    import dual_timer_pkg::*;

    divider_state_type state;       // registered phase
    divider_state_type next_state;  // phase for the next cycle

    // true on the last cycle of every period of length div
    function automatic logic on_boundary(input logic [`DIV_PHASE_W-1:0] phase, input int div);
        int rem;
        rem = int'(phase) % div;
        return (rem == div - 1);
    endfunction : on_boundary

    // phase runs over the common span of all ratios
    always_comb begin
        next_state = state;
        if (int'(state.phase) == `DIV_SPAN - 1) begin
            next_state.phase = '0;
        end else begin
            next_state.phase = state.phase + `DIV_PHASE_W'(1);
        end
        tick_o[0] = on_boundary(state.phase, `DIV_SCALE0);
        tick_o[1] = on_boundary(state.phase, `DIV_SCALE1);
        tick_o[2] = on_boundary(state.phase, `DIV_SCALE2);
        tick_o[3] = on_boundary(state.phase, `DIV_SCALE3);
    end

    // phase register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state.phase <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : prescale_divider

// File: src/count_unit.sv
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module count_unit (
    input  wire logic                    sys_clk_i,
    input  wire logic                    srst_i,
    input  wire logic                    tick_i,
    input  wire logic                    allow_i,
    input  wire logic                    wr_low_i,
    input  wire logic                    wr_high_i,
    input  wire logic [`REG_DATA_W-1:0]  wdata_i,
    output logic      [`COUNT_W-1:0]     count_o,
    output logic                         wrap_o
);
    import dual_timer_pkg::*;

    count_state_type state;       // current 13-bit count
    count_state_type next_state;  // count for the next cycle

    // increment, wrap detect and byte loads
    always_comb begin
        next_state = state;
        wrap_o     = 1'b0;
        // one step per tick while counting is allowed
        if (tick_i && allow_i) begin
            next_state.count = state.count + `COUNT_ONE;
            wrap_o           = (state.count == `COUNT_ONES);
        end
        // software loads win over the increment of the same byte
        if (wr_low_i) begin
            next_state.count[`LOW_W-1:0] = wdata_i[`LOW_W-1:0];
        end
        if (wr_high_i) begin
            next_state.count[`COUNT_W-1:`LOW_W] = wdata_i;
        end
        count_o = state.count;
    end

    // count register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state.count <= `RST_COUNT;
        end else begin
            state <= next_state;
        end
    end

endmodule : count_unit

// File: verification/pin_partner.sv
`timescale 1ns/1ps

module pin_partner #(
    parameter int LOW_CYCLES = 2 // cycles a count pin stays low per edge
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           srst_i,
    input  wire logic [1:0]                     edge_req_i,
    input  wire logic [1:0]                     gate_i,
    input  wire dual_timer_pkg::vector_ack_type vec_req_i,
    output dual_timer_pkg::timer_pins_type      pins_o,
    output dual_timer_pkg::vector_ack_type      ack_o
);
    import dual_timer_pkg::*;
    logic [1:0][3:0] low_cnt; // low time left per count pin
    logic [1:0]      gate_q;  // external input levels as driven
    // count pins idle high and drop once per request, so each request is one falling edge
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (srst_i) begin
                low_cnt[i] <= 4'h0;
            end else if (edge_req_i[i]) begin
                low_cnt[i] <= 4'(LOW_CYCLES);
            end else if (low_cnt[i] != 4'h0) begin
                low_cnt[i] <= low_cnt[i] - 4'h1;
            end
        end
        gate_q <= gate_i;
        ack_o  <= srst_i ? '0 : vec_req_i; // vectoring is a one-cycle pulse
    end
    assign pins_o = '{count_pin: {low_cnt[1] == 4'h0, low_cnt[0] == 4'h0}, ext_irq_input: gate_q};
endmodule : pin_partner

// File: verification/dual_timer_13bit_mode_props.sv
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module dual_timer_13bit_mode_props (
    input wire logic                           sys_clk_i,
    input wire logic                           srst_i,
    input wire dual_timer_pkg::reg_req_type    req_i,
    input wire dual_timer_pkg::timer_pins_type pins_i,
    input wire dual_timer_pkg::vector_ack_type ack_i,
    input wire logic [`REG_DATA_W-1:0]         rdata_o,
    input wire logic                           irq_o,
    input wire logic [1:0]                     overflow_flag_o,
    input wire logic [1:0]                     ext_irq_flag_o
);
    import dual_timer_pkg::*;
    logic       soft_clr;             // software write that may clear flags
    logic [1:0] ovf_clr, ovf_clr_q;   // overflow flag clear causes, now and last cycle
    logic [1:0] ext_clr, ext_clr_q;   // external flag clear causes, now and last cycle
    logic [1:0] ovf_keep, ext_keep;   // set flags with no clear cause in sight
    logic       irq_cause;            // anything that may lower the interrupt
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    assign soft_clr  = req_i.wr && (req_i.addr == `OFS_PAIR_CONTROL || req_i.addr == `OFS_IRQ_CLEAR);
    assign ovf_clr   = ack_i.timer_vector | {2{soft_clr}};
    assign ext_clr   = ack_i.ext_vector | {2{soft_clr}};
    assign ovf_keep  = overflow_flag_o & ~ovf_clr & ~ovf_clr_q;
    assign ext_keep  = ext_irq_flag_o & ~ext_clr & ~ext_clr_q;
    assign irq_cause = (|ack_i) || (req_i.wr && req_i.addr >= `OFS_PAIR_CONTROL);
    // delayed clear causes cover the registered flag copies
    always_ff @(posedge sys_clk_i) begin
        ovf_clr_q <= ovf_clr;
        ext_clr_q <= ext_clr;
    end
    property p_rd_idle;
        !$past(req_i.rd) |-> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_low_mask;
        $past(req_i.rd) && ($past(req_i.addr) == `OFS_ZERO_LOW || $past(req_i.addr) == `OFS_ONE_LOW)
            |-> rdata_o[7:5] == 3'h0;
    endproperty
    a_low_mask: assert property (p_low_mask) else $error("low byte upper bits not zero");
    property p_unmapped;
        $past(req_i.rd) && ($past(req_i.addr) < `OFS_PAIR_CONTROL || $past(req_i.addr) > `OFS_IRQ_ENABLE
            || $past(req_i.addr) == `OFS_IRQ_CLEAR) |-> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reset_zero;
        $fell(srst_i) |-> overflow_flag_o == 2'b00 && ext_irq_flag_o == 2'b00 && !irq_o;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not clear after reset");
    property p_ovf_sticky;
        1'b1 |=> (overflow_flag_o & $past(ovf_keep)) == $past(ovf_keep);
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
    property p_ext_sticky;
        1'b1 |=> (ext_irq_flag_o & $past(ext_keep)) == $past(ext_keep);
    endproperty
    a_ext_sticky: assert property (p_ext_sticky) else $error("external flag dropped");
    property p_sw_set;
        req_i.wr && req_i.addr == `OFS_PAIR_CONTROL && req_i.wdata[`TF0_BIT] |-> ##[1:2] overflow_flag_o[0];
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software set of overflow flag lost");
    property p_irq_fall;
        $fell(irq_o) |-> $past(irq_cause) || $past(irq_cause, 2) || $past(irq_cause, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without cause");
endmodule : dual_timer_13bit_mode_props

bind dual_timer_13bit_mode dual_timer_13bit_mode_props props_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req_i), .pins_i(pins_i), .ack_i(ack_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .overflow_flag_o(overflow_flag_o), .ext_irq_flag_o(ext_irq_flag_o)
);

// File: verification/dual_timer_13bit_mode_tb_top.sv
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module dual_timer_13bit_mode_tb_top;
    import dual_timer_pkg::*;
    logic           sys_clk_i;  // bench clock
    logic           srst_i;     // bench reset
    reg_req_type    req;        // register bus request
    timer_pins_type pins;       // pins from the partner
    vector_ack_type ack;        // vectoring from the partner
    vector_ack_type vec;        // vectoring request to the partner
    logic [1:0]     edge_req;   // one falling edge per request
    logic [1:0]     gate;       // external input levels
    logic [7:0]     rdata;      // read data
    logic           irq;        // interrupt line
    logic [1:0]     ovf;        // overflow flags
    logic [1:0]     ext;        // external flags
    int             fail_count; // mismatches
    int             n_tests;    // comparisons
    dual_timer_13bit_mode dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req), .pins_i(pins),
        .ack_i(ack), .rdata_o(rdata), .irq_o(irq), .overflow_flag_o(ovf), .ext_irq_flag_o(ext));
    pin_partner partner_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .edge_req_i(edge_req),
        .gate_i(gate), .vec_req_i(vec), .pins_o(pins), .ack_o(ack));
    // free-running 200 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // counts and prints the verdict
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // one comparison of a byte-wide result
    task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_tests++;
        if (got !== ex) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    // single-cycle register write
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        req.wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus_wr
    // register read, data checked in the cycle after the strobe under a mask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        req.rd <= 1'b0;
        @(negedge sys_clk_i);
        cmp("read data", ex, rdata & m);
        @(posedge sys_clk_i);
    endtask : rd_chk
    // flag and interrupt outputs, once settled
    task automatic chk_out(input logic [1:0] eo, input logic [1:0] ee, input logic ei);
        repeat (2) @(negedge sys_clk_i);
        cmp("overflow flags", {6'h00, eo}, {6'h00, ovf});
        cmp("external flags", {6'h00, ee}, {6'h00, ext});
        cmp("interrupt", {7'h00, ei}, {7'h00, irq});
        @(posedge sys_clk_i);
    endtask : chk_out
    // falling edges on a count pin, spaced apart
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            edge_req[i] <= 1'b1;
            @(posedge sys_clk_i);
            edge_req[i] <= 1'b0;
            repeat (5) @(posedge sys_clk_i);
        end
    endtask : pulse
    // cpu vectoring through the partner, order is timer pair then external pair
    task automatic vector(input logic [3:0] v);
        vec <= v;
        @(posedge sys_clk_i);
        vec <= '0;
        repeat (3) @(posedge sys_clk_i);
    endtask : vector
    // bounded wait for timer zero overflow
    task automatic wait_ovf;
        int k;
        for (k = 0; k < 64 && ovf[0] !== 1'b1; k++) @(negedge sys_clk_i);
        if (k == 64) begin
            fail_count++;
            stop_test();
        end
        @(posedge sys_clk_i);
    endtask : wait_ovf
    // main sequence; external inputs idle inactive for the reset polarity
    initial begin
        fail_count = 0;
        n_tests = 0;
        srst_i = 1'b1;
        req = '0;
        vec = '0;
        edge_req = '0;
        gate = 2'b11;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd_chk(`OFS_PAIR_CONTROL, 8'h00, 8'hFF);
        rd_chk(8'hA0, 8'h00, 8'hFF);
        chk_out(2'b00, 2'b00, 1'b0);
        bus_wr(`OFS_ZERO_LOW, 8'hFE);
        bus_wr(`OFS_ZERO_HIGH, 8'hFF);
        rd_chk(`OFS_ZERO_LOW, 8'h1E, 8'h1F);
        rd_chk(`OFS_ZERO_HIGH, 8'hFF, 8'hFF);
        bus_wr(`OFS_IRQ_ENABLE, 8'h01);
        bus_wr(`OFS_CLOCK_SCALE, 8'h08);
        bus_wr(`OFS_PAIR_CONTROL, 8'h10);
        wait_ovf();
        chk_out(2'b01, 2'b00, 1'b1);
        rd_chk(`OFS_IRQ_STATUS, 8'h01, 8'h01);
        bus_wr(`OFS_IRQ_ENABLE, 8'h00);
        chk_out(2'b01, 2'b00, 1'b0);
        bus_wr(`OFS_PAIR_CONTROL, 8'h00);
        rd_chk(`OFS_ZERO_HIGH, 8'h00, 8'hFF);
        chk_out(2'b00, 2'b00, 1'b0);
        bus_wr(`OFS_PAIR_CONTROL, 8'h20);
        chk_out(2'b01, 2'b00, 1'b0);
        vector(4'b0100);
        chk_out(2'b00, 2'b00, 1'b0);
        bus_wr(`OFS_IRQ_CLEAR, 8'h01);
        bus_wr(`OFS_IRQ_ENABLE, 8'h01);
        chk_out(2'b00, 2'b00, 1'b0);
        // timer zero on the divide-by-four prescaler: 48 allowed cycles give twelve steps
        bus_wr(`OFS_ZERO_LOW, 8'h00);
        bus_wr(`OFS_CLOCK_SCALE, 8'h01);
        bus_wr(`OFS_PAIR_CONTROL, 8'h10);
        repeat (46) @(posedge sys_clk_i);
        bus_wr(`OFS_PAIR_CONTROL, 8'h00);
        rd_chk(`OFS_ZERO_LOW, 8'h0C, 8'h1F);
        // timer one counting pin edges behind its gate
        bus_wr(`OFS_MODE, 8'hC0);
        bus_wr(`OFS_ONE_LOW, 8'h05);
        bus_wr(`OFS_ONE_HIGH, 8'h00);
        bus_wr(`OFS_PAIR_CONTROL, 8'h44);
        pulse(1, 3);
        rd_chk(`OFS_ONE_LOW, 8'h05, 8'h1F);
        gate[1] <= 1'b0;
        pulse(1, 3);
        rd_chk(`OFS_ONE_LOW, 8'h08, 8'h1F);
        bus_wr(`OFS_EXT_CONFIG, 8'h80);
        pulse(1, 2);
        rd_chk(`OFS_ONE_LOW, 8'h08, 8'h1F);
        bus_wr(`OFS_ONE_LOW, 8'h1F);
        bus_wr(`OFS_ONE_HIGH, 8'hFF);
        gate[1] <= 1'b1;
        pulse(1, 1);
        chk_out(2'b10, 2'b10, 1'b0);
        rd_chk(`OFS_ONE_HIGH, 8'h00, 8'hFF);
        vector(4'b1000);
        chk_out(2'b00, 2'b10, 1'b0);
        gate[1] <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        bus_wr(`OFS_PAIR_CONTROL, 8'h00);
        chk_out(2'b00, 2'b00, 1'b0);
        // external zero in edge mode, then level mode
        bus_wr(`OFS_PAIR_CONTROL, 8'h01);
        gate[0] <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk_out(2'b00, 2'b01, 1'b0);
        bus_wr(`OFS_IRQ_ENABLE, 8'h04);
        chk_out(2'b00, 2'b01, 1'b1);
        vector(4'b0001);
        chk_out(2'b00, 2'b00, 1'b1);
        bus_wr(`OFS_PAIR_CONTROL, 8'h00);
        chk_out(2'b00, 2'b01, 1'b1);
        vector(4'b0001);
        chk_out(2'b00, 2'b01, 1'b1);
        gate[0] <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        bus_wr(`OFS_PAIR_CONTROL, 8'h00);
        bus_wr(`OFS_IRQ_CLEAR, 8'h04);
        chk_out(2'b00, 2'b00, 1'b0);
        stop_test();
    end
endmodule : dual_timer_13bit_mode_tb_top
